// *** common/tpu_pkg.sv ***
// constants and types shared by the timer pwm unit
package tpu_pkg;

  // register byte addresses, one aligned word each
  localparam logic [7:0] OFS_SC = 8'h00;
  localparam logic [7:0] OFS_CNTH = 8'h04;
  localparam logic [7:0] OFS_CNTL = 8'h08;
  localparam logic [7:0] OFS_MODH = 8'h0c;
  localparam logic [7:0] OFS_MODL = 8'h10;
  localparam logic [7:0] OFS_CH_BASE = 8'h14;
  localparam logic [7:0] OFS_CH_STRIDE = 8'h0c;
  localparam logic [7:0] OFS_CH_SC = 8'h00;
  localparam logic [7:0] OFS_CH_VH = 8'h04;
  localparam logic [7:0] OFS_CH_VL = 8'h08;

  // timer_status_control fields
  localparam int SC_TOF = 7;
  localparam int SC_UP_DOWN_COUNT_SELECT = 5;
  localparam int SC_CLKS_LO = 3;
  localparam int SC_PS_LO = 0;

  // channel status/control fields
  localparam int CH_CHF = 7;
  localparam int CH_MS_LO = 4;
  localparam int CH_ELS_LO = 2;

  // reset values
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] MOD_RST = 16'h0000;
  localparam logic [15:0] CV_RST = 16'h0000;

  // counter landmarks
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] FREE_LAST = 16'hffff;
  localparam logic [15:0] FREE_PENULT = 16'hfffe;

  // channel_mode_select, edge_level_select and clock select codes
  localparam logic [1:0] MS_CAPTURE = 2'h0;
  localparam logic [1:0] MS_COMPARE = 2'h1;
  localparam logic [1:0] ELS_NONE = 2'h0;
  localparam logic [1:0] ELS_TOGGLE = 2'h1;
  localparam logic [1:0] ELS_CLEAR = 2'h2;
  localparam logic [1:0] ELS_SET = 2'h3;
  localparam logic [1:0] CLKS_STOP = 2'h0;

  typedef enum logic [0:0] {
    BUS_IDLE,
    BUS_ACCESS
  } tpu_bus_t;

endpackage

// *** core/tpu_top.sv ***
// timer pwm unit: 16-bit counter, modulo, channels, ahb-lite registers
//
// Design decisions made here: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - reset or counter write clears counter, latch
// - debug freezes counter and its read latch
// - debug writes to control/counter reset read latch
// - at modulo, restart from zero, set overflow
// - half-written modulo suppresses overflow flag
// - modulo resets to zero, meaning free run
// - modulo buffered; loads per clock source select
// - control write resets two-byte write latches
// - capture mode: rising, falling or both edges
// - compare mode: software, toggle, clear, set
// - edge pwm high-true or low-true pulses
// - up/down counting gives center-aligned pwm
// - channel value reset clear; capture or compare
// - capture value read latches both bytes
// - edge pwm zero is 0%, above modulo 100%
// - edge pwm channel value buffered like modulo
// - center pwm width twice value, period twice
// - center pwm zero or negative gives 0%
// - modulo zero free runs; reversal needs nonzero match
module tpu_top #(
  parameter int NCH = 2
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic bgdActive,
  input wire logic [NCH-1:0] chIn,
  output logic [NCH-1:0] chOut,
  output logic [NCH-1:0] chOutEn
);
  import tpu_pkg::*;

  typedef struct packed {
    tpu_bus_t bus;
    logic [7:0] addr;
    logic wr;
    logic hit;
    logic hready;
    logic hresp;
    logic [31:0] hrdata;
    logic overflow_flag;
    logic up_down_count_select;
    logic [1:0] clks;
    logic [2:0] ps;
    logic [6:0] psCnt;
    logic [15:0] cnt;
    logic down;
    logic [15:0] cntBuf;
    logic cntLat;
    logic cntRdH;
    logic cntRdL;
    logic [15:0] mod;
    logic [15:0] modBuf;
    logic modWrH;
    logic modWrL;
    logic [NCH-1:0] chf;
    logic [NCH-1:0][1:0] ms;
    logic [NCH-1:0][1:0] els;
    logic [NCH-1:0][15:0] cv;
    logic [NCH-1:0][15:0] cvBuf;
    logic [NCH-1:0] cvWrH;
    logic [NCH-1:0] cvWrL;
    logic [NCH-1:0][15:0] capBuf;
    logic [NCH-1:0] capLat;
    logic [NCH-1:0] capRdH;
    logic [NCH-1:0] capRdL;
    logic [NCH-1:0] pinPrev;
    logic [NCH-1:0] out;
    logic [NCH-1:0] oe;
  } tpu_state_t;

  tpu_state_t st_q;
  tpu_state_t st_d;
  logic [1:0] rstSync_q;
  logic rstLn;
  logic acc;
  logic accWr;
  logic accRd;
  logic cntWr;
  logic tick;
  logic ovf;
  logic step;
  logic [6:0] psLimit;
  logic [15:0] nxt;
  logic [7:0] rd;
  logic [7:0] wd;
  logic [7:0] chOfs;
  logic capMode;
  logic ocMode;
  logic epwm;
  logic hi;
  logic rise;
  logic fall;

  // reset is released through two flops; first flop feeds only the second
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rstSync_q <= 2'b00;
    end else begin
      rstSync_q <= {rstSync_q[0], 1'b1};
    end
  end
  assign rstLn = rstSync_q[1];

  always_comb begin
    st_d = st_q;
    rd = 8'h00;
    wd = hwdata[7:0];
    acc = (st_q.bus == BUS_ACCESS) && st_q.hit;
    accWr = acc && st_q.wr;
    accRd = acc && !st_q.wr;
    cntWr = accWr && ((st_q.addr == OFS_CNTH) || (st_q.addr == OFS_CNTL));
    chOfs = 8'h00;
    capMode = 1'b0;
    ocMode = 1'b0;
    epwm = 1'b0;
    hi = 1'b0;
    rise = 1'b0;
    fall = 1'b0;

    // ahb-lite slave: one wait state so read data comes from a flop
    case (st_q.bus)
      BUS_IDLE: begin
        if (hsel && hready && htrans[1]) begin
          st_d.bus = BUS_ACCESS;
          st_d.addr = haddr[7:0];
          st_d.wr = hwrite;
          st_d.hit = (haddr[31:8] == 24'h000000);
          st_d.hready = 1'b0;
        end
      end
      BUS_ACCESS: begin
        st_d.bus = BUS_IDLE;
        st_d.hready = 1'b1;
      end
      default: begin
        st_d.bus = BUS_IDLE;
        st_d.hready = 1'b1;
      end
    endcase

    if (acc) begin
      case (st_q.addr)
        OFS_SC: begin
          rd = {st_q.overflow_flag, 1'b0, st_q.up_down_count_select, st_q.clks, st_q.ps};
          if (st_q.wr) begin
            if (!wd[SC_TOF])
              st_d.overflow_flag = 1'b0;
            st_d.up_down_count_select = wd[SC_UP_DOWN_COUNT_SELECT];
            st_d.clks = wd[SC_CLKS_LO +: 2];
            st_d.ps = wd[SC_PS_LO +: 3];
            st_d.modWrH = 1'b0;
            st_d.modWrL = 1'b0;
            st_d.cvWrH = '0;
            st_d.cvWrL = '0;
            if (bgdActive) begin
              st_d.cntLat = 1'b0;
              st_d.cntRdH = 1'b0;
              st_d.cntRdL = 1'b0;
            end
          end
        end
        OFS_CNTH, OFS_CNTL: begin
          if (st_q.addr == OFS_CNTH)
            rd = st_q.cntLat ? st_q.cntBuf[15:8] : st_q.cnt[15:8];
          else
            rd = st_q.cntLat ? st_q.cntBuf[7:0] : st_q.cnt[7:0];
          if (st_q.wr) begin
            st_d.cntLat = 1'b0;
            st_d.cntRdH = 1'b0;
            st_d.cntRdL = 1'b0;
          end else if (!bgdActive) begin
            if (!st_q.cntLat) begin
              st_d.cntBuf = st_q.cnt;
              st_d.cntLat = 1'b1;
            end
            if (st_q.addr == OFS_CNTH)
              st_d.cntRdH = 1'b1;
            else
              st_d.cntRdL = 1'b1;
            // the second half read releases the latch
            if (st_q.cntLat && ((st_q.addr == OFS_CNTH) ? st_q.cntRdL : st_q.cntRdH)) begin
              st_d.cntLat = 1'b0;
              st_d.cntRdH = 1'b0;
              st_d.cntRdL = 1'b0;
            end
          end
        end
        OFS_MODH, OFS_MODL: begin
          rd = (st_q.addr == OFS_MODH) ? st_q.mod[15:8] : st_q.mod[7:0];
          if (st_q.wr) begin
            if (st_q.addr == OFS_MODH)
              st_d.modBuf[15:8] = wd;
            else
              st_d.modBuf[7:0] = wd;
            if ((st_q.addr == OFS_MODH) ? (st_q.modWrL && !st_q.modWrH)
                                        : (st_q.modWrH && !st_q.modWrL)) begin
              st_d.modWrH = 1'b1;
              st_d.modWrL = 1'b1;
              if (st_q.clks == CLKS_STOP) begin
                st_d.mod = st_d.modBuf;
                st_d.modWrH = 1'b0;
                st_d.modWrL = 1'b0;
              end
            end else begin
              st_d.modWrH = (st_q.addr == OFS_MODH);
              st_d.modWrL = (st_q.addr == OFS_MODL);
            end
          end
        end
        default: begin
          for (int i = 0; i < NCH; i++) begin
            chOfs = 8'(st_q.addr - 8'(OFS_CH_BASE + 8'(i) * OFS_CH_STRIDE));
            capMode = !st_q.up_down_count_select && (st_q.ms[i] == MS_CAPTURE);
            epwm = !st_q.up_down_count_select && st_q.ms[i][1];
            if (st_q.addr >= 8'(OFS_CH_BASE + 8'(i) * OFS_CH_STRIDE)
                && chOfs < OFS_CH_STRIDE) begin
              if (chOfs == OFS_CH_SC) begin
                rd = {st_q.chf[i], 1'b0, st_q.ms[i], st_q.els[i], 2'b00};
                if (st_q.wr) begin
                  if (!wd[CH_CHF])
                    st_d.chf[i] = 1'b0;
                  st_d.ms[i] = wd[CH_MS_LO +: 2];
                  st_d.els[i] = wd[CH_ELS_LO +: 2];
                end
              end else if (chOfs == OFS_CH_VH || chOfs == OFS_CH_VL) begin
                if (chOfs == OFS_CH_VH)
                  rd = st_q.capLat[i] ? st_q.capBuf[i][15:8] : st_q.cv[i][15:8];
                else
                  rd = st_q.capLat[i] ? st_q.capBuf[i][7:0] : st_q.cv[i][7:0];
                if (st_q.wr) begin
                  if (chOfs == OFS_CH_VH)
                    st_d.cvBuf[i][15:8] = wd;
                  else
                    st_d.cvBuf[i][7:0] = wd;
                  if ((chOfs == OFS_CH_VH) ? (st_q.cvWrL[i] && !st_q.cvWrH[i])
                                           : (st_q.cvWrH[i] && !st_q.cvWrL[i])) begin
                    st_d.cvWrH[i] = 1'b1;
                    st_d.cvWrL[i] = 1'b1;
                    // only edge pwm with a running clock waits for the period end
                    if (!epwm || st_q.clks == CLKS_STOP) begin
                      st_d.cv[i] = st_d.cvBuf[i];
                      st_d.cvWrH[i] = 1'b0;
                      st_d.cvWrL[i] = 1'b0;
                    end
                  end else begin
                    st_d.cvWrH[i] = (chOfs == OFS_CH_VH);
                    st_d.cvWrL[i] = (chOfs == OFS_CH_VL);
                  end
                end else if (capMode) begin
                  if (!st_q.capLat[i]) begin
                    st_d.capBuf[i] = st_q.cv[i];
                    st_d.capLat[i] = 1'b1;
                  end
                  if (chOfs == OFS_CH_VH)
                    st_d.capRdH[i] = 1'b1;
                  else
                    st_d.capRdL[i] = 1'b1;
                  if (st_q.capLat[i]
                      && ((chOfs == OFS_CH_VH) ? st_q.capRdL[i] : st_q.capRdH[i])) begin
                    st_d.capLat[i] = 1'b0;
                    st_d.capRdH[i] = 1'b0;
                    st_d.capRdL[i] = 1'b0;
                  end
                end
              end
            end
          end
        end
      endcase
    end
    if (st_q.bus == BUS_ACCESS)
      st_d.hrdata = accRd ? {24'h000000, rd} : 32'h00000000;

    // prescaler and counting clock; debug and a stopped source hold the prescaler and stop the count tick
    psLimit = 7'((8'h01 << st_q.ps) - 8'h01);
    tick = (st_q.clks != CLKS_STOP) && !bgdActive && (st_q.psCnt == psLimit);
    if ((st_q.clks != CLKS_STOP) && !bgdActive)
      st_d.psCnt = tick ? 7'h00 : 7'(st_q.psCnt + 7'h01);

    nxt = st_q.cnt;
    ovf = 1'b0;
    step = 1'b0;
    if (tick) begin
      step = !st_q.down && ((st_q.mod != MOD_RST) ? (st_q.cnt == 16'(st_q.mod - 16'h0001))
                                                 : (st_q.cnt == FREE_PENULT));
      if (!st_q.up_down_count_select) begin
        st_d.down = 1'b0;
        if ((st_q.mod != MOD_RST && st_q.cnt == st_q.mod)
            || (st_q.mod == MOD_RST && st_q.cnt == FREE_LAST)) begin
          nxt = CNT_ZERO;
          ovf = 1'b1;
        end else begin
          nxt = 16'(st_q.cnt + 16'h0001);
        end
      end else if (!st_q.down) begin
        // a zero modulo never matches, so the count never turns
        if (st_q.mod != MOD_RST && st_q.cnt == st_q.mod) begin
          st_d.down = 1'b1;
          nxt = 16'(st_q.cnt - 16'h0001);
        end else begin
          nxt = 16'(st_q.cnt + 16'h0001);
        end
      end else if (st_q.cnt == CNT_ZERO) begin
        st_d.down = 1'b0;
        nxt = 16'(st_q.cnt + 16'h0001);
        ovf = 1'b1;
      end else begin
        nxt = 16'(st_q.cnt - 16'h0001);
      end
    end
    // overflow wins over a same-cycle clear; blocked by half a modulo pair
    if (ovf && (st_q.modWrH == st_q.modWrL))
      st_d.overflow_flag = 1'b1;
    if (step && st_q.modWrH && st_q.modWrL) begin
      st_d.mod = st_q.modBuf;
      st_d.modWrH = 1'b0;
      st_d.modWrL = 1'b0;
    end
    st_d.cnt = cntWr ? CNT_RST : nxt;

    for (int i = 0; i < NCH; i++) begin
      capMode = !st_q.up_down_count_select && (st_q.ms[i] == MS_CAPTURE);
      ocMode = !st_q.up_down_count_select && (st_q.ms[i] == MS_COMPARE);
      epwm = !st_q.up_down_count_select && st_q.ms[i][1];
      rise = chIn[i] && !st_q.pinPrev[i];
      fall = !chIn[i] && st_q.pinPrev[i];
      st_d.pinPrev[i] = chIn[i];
      st_d.oe[i] = !capMode && (st_q.els[i] != ELS_NONE);
      if (capMode) begin
        if ((rise && st_q.els[i][0]) || (fall && st_q.els[i][1])) begin
          st_d.cv[i] = st_q.cnt;
          st_d.chf[i] = 1'b1;
        end
      end else if (tick && st_q.cnt == st_q.cv[i]) begin
        st_d.chf[i] = 1'b1;
      end
      if (ocMode && tick && st_q.cnt == st_q.cv[i]) begin
        case (st_q.els[i])
          ELS_TOGGLE: st_d.out[i] = !st_q.out[i];
          ELS_CLEAR: st_d.out[i] = 1'b0;
          ELS_SET: st_d.out[i] = 1'b1;
          default: st_d.out[i] = st_q.out[i];
        endcase
      end
      if (epwm) begin
        // zero never goes active; above the modulo never ends
        hi = st_d.cnt < st_q.cv[i];
        st_d.out[i] = st_q.els[i][1] ? hi : !hi;
        if (step && st_q.cvWrH[i] && st_q.cvWrL[i]) begin
          st_d.cv[i] = st_q.cvBuf[i];
          st_d.cvWrH[i] = 1'b0;
          st_d.cvWrL[i] = 1'b0;
        end
      end
      if (st_q.up_down_count_select) begin
        // the value itself counts on the way down, so the width is twice the value
        hi = !st_q.cv[i][15] && (st_q.cv[i] != CV_RST)
             && ((st_d.cnt < st_q.cv[i]) || (st_d.cnt == st_q.cv[i] && st_d.down));
        st_d.out[i] = st_q.els[i][0] ? !hi : hi;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstLn) begin
    if (!rstLn) begin
      st_q <= '0;
      st_q.hready <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign hreadyout = st_q.hready;
  assign hrdata = st_q.hrdata;
  assign hresp = st_q.hresp;
  assign chOut = st_q.out;
  assign chOutEn = st_q.oe;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstLn);

  sequence modFirstHalf;
    accWr && (st_q.addr == OFS_MODH) && !st_q.modWrL;
  endsequence

  sequence modSecondHalfStopped;
    accWr && (st_q.addr == OFS_MODL) && st_q.modWrH && !st_q.modWrL
      && (st_q.clks == CLKS_STOP);
  endsequence

  chk_cnt_write_clear: assert property (cntWr |=> (st_q.cnt == CNT_ZERO) && !st_q.cntLat)
    else $error("counter write did not clear counter");
  chk_debug_freeze: assert property (bgdActive && !cntWr && !(accWr && st_q.addr == OFS_SC)
                                     |=> $stable(st_q.cnt)
                                     && $stable(st_q.cntLat))
    else $error("counter moved in debug");
  chk_debug_sc_unlatch: assert property (bgdActive && accWr && st_q.addr == OFS_SC
                                         |=> !st_q.cntLat)
    else $error("debug control write left counter latch");
  chk_modulo_wrap: assert property (tick && !st_q.up_down_count_select && st_q.mod != MOD_RST
                                    && st_q.cnt == st_q.mod && !cntWr
                                    && st_q.modWrH == st_q.modWrL
                                    |=> st_q.cnt == CNT_ZERO && st_q.overflow_flag)
    else $error("no wrap with overflow at modulo");
  chk_mod_half_inhibit: assert property (modFirstHalf ##1 (!st_q.overflow_flag && st_q.modWrH
                                         && !st_q.modWrL) |=> !st_q.overflow_flag)
    else $error("overflow set with half modulo written");
  chk_free_run_wrap: assert property (tick && !st_q.up_down_count_select && st_q.mod == MOD_RST
                                      && st_q.cnt == FREE_LAST && !cntWr
                                      |=> st_q.cnt == CNT_ZERO)
    else $error("free running count did not wrap");
  chk_mod_load_stopped: assert property (modSecondHalfStopped
                                         |=> st_q.mod == {st_q.modBuf[15:8], $past(wd)})
    else $error("modulo not loaded on second byte");
  chk_sc_write_unlatch: assert property (accWr && st_q.addr == OFS_SC
                                         |=> !st_q.modWrH && !st_q.modWrL)
    else $error("control write left write latch");
  chk_epwm_zero_duty: assert property ((!st_q.up_down_count_select && st_q.ms[1] == 2'h2
                                        && st_q.els[1] == ELS_CLEAR
                                        && st_q.cv[1] == CV_RST)[*2] |-> !chOut[1])
    else $error("edge pwm zero value drove output");
  chk_cpwm_neg_duty: assert property ((st_q.up_down_count_select && st_q.els[1] == ELS_CLEAR
                                       && st_q.cv[1][15])[*2] |-> !chOut[1])
    else $error("center pwm negative value drove output");
  chk_stopped_hold: assert property (st_q.clks == CLKS_STOP && !cntWr
                                     |=> $stable(st_q.cnt))
    else $error("counter moved with clock stopped");

endmodule // tpu_top

`default_nettype wire

// *** sim/tpu_pin_source.sv ***
// external pin source model driving the timer channel inputs
`timescale 1ns/1ps
`default_nettype none
module tpu_pin_source #(
  parameter int NCH = 2
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [NCH-1:0] pinLevel,
  output logic [NCH-1:0] chIn
);
  // pins move just after an edge, so the design sees each level for whole cycles
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      chIn <= '0;
    end else begin
      chIn <= pinLevel;
    end
  end
endmodule // tpu_pin_source
`default_nettype wire

// *** sim/tpu_top_bench.sv ***
// self-checking bench for the timer pwm unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin mismatches++; \
  $display("unexpected %s exp %h got %h", nm, ex, gt); end end
module tpu_top_bench;
  import tpu_pkg::*;
  localparam int LIMIT = 6000;
  localparam logic [15:0] EP_V [4] = '{16'h0000, 16'h0003, 16'h0009, 16'h0001};
  localparam logic [7:0] EP_H [4] = '{8'h00, 8'h06, 8'h0c, 8'h0a};
  localparam logic [15:0] CP_V [5] = '{16'h0002, 16'h0000, 16'h8001, 16'h0005, 16'h0001};
  localparam logic [7:0] CP_H [5] = '{8'h08, 8'h00, 8'h00, 8'h10, 8'h0c};
  logic core_clk, rstn, hsel, hwrite, bgdActive, hreadyout, hresp, a;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, chIn, chOut, chOutEn, pinLevel;
  logic [2:0] hsize;
  logic [23:0] page;
  logic [7:0] rb, hc;
  logic [15:0] cntX, cntY;
  int mismatches, checked;
  int cycles = 0;

  tpu_top #(.NCH(2)) uut (.core_clk(core_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .bgdActive(bgdActive),
    .chIn(chIn), .chOut(chOut), .chOutEn(chOutEn));
  tpu_pin_source #(.NCH(2)) pins (.core_clk(core_clk), .rstn(rstn), .pinLevel(pinLevel),
    .chIn(chIn));

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // a hang anywhere ends here as a failure
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      mismatches++;
      wrap_up();
    end
  end

  // hready is sampled before the edge's own updates land, so no fixed latency is assumed
  task automatic xfer(input logic w, input logic [7:0] ad, input logic [7:0] d,
                      output logic [7:0] q);
    @(posedge core_clk);
    hsel <= 1'b1;
    haddr <= {page, ad};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    q = hrdata[7:0];
    `CHK("hresp", 1'b0, hresp)
  endtask

  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    logic [7:0] q;
    xfer(1'b1, ad, d, q);
  endtask

  task automatic rd(input logic [7:0] ad);
    xfer(1'b0, ad, 8'h00, rb);
  endtask

  // high byte first; each pair sits one word apart
  task automatic rd16(input logic [7:0] hi, output logic [15:0] v);
    rd(hi);
    v[15:8] = rb;
    rd(hi + 8'h04);
    v[7:0] = rb;
  endtask

  task automatic wr16(input logic [7:0] hi, input logic [15:0] v);
    wr(hi, v[15:8]);
    wr(hi + 8'h04, v[7:0]);
  endtask

  function automatic logic [7:0] ch(input int n, input logic [7:0] o);
    return OFS_CH_BASE + OFS_CH_STRIDE * 8'(n) + o;
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // counts high cycles of channel 1 over a whole number of periods
  task automatic highs(input int n, output logic [7:0] h);
    h = 8'h00;
    repeat (n) begin
      @(posedge core_clk);
      if (chOut[1] === 1'b1) h++;
    end
  endtask

  initial begin
    rstn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    bgdActive = 1'b0;
    pinLevel = 2'b00;
    page = 24'h0;
    mismatches = 0;
    checked = 0;
    tick(20);
    rstn <= 1'b1;
    tick(4);
    rd(OFS_SC);
    `CHK("status", 8'h00, rb)
    rd16(OFS_MODH, cntX);
    `CHK("modulo reset", MOD_RST, cntX)
    rd16(OFS_CNTH, cntX);
    `CHK("counter reset", CNT_RST, cntX)
    rd16(ch(0, OFS_CH_VH), cntX);
    `CHK("value reset", CV_RST, cntX)
    page = 24'h1;
    rd(8'h00);
    `CHK("unmapped", 8'h00, rb)
    page = 24'h0;
    rd16(OFS_CNTH, cntX);
    `CHK("stopped count", CNT_RST, cntX)
    // free run, then park the count at a nonzero value
    wr(OFS_SC, 8'h08);
    tick(50);
    wr(OFS_SC, 8'h00);
    rd16(OFS_CNTH, cntX);
    `CHK("free run", 1'b1, cntX > 16'h0020)
    rd16(OFS_CNTH, cntY);
    `CHK("held count", cntX, cntY)
    for (int e = 1; e < 4; e++) begin
      wr(ch(0, OFS_CH_SC), 8'(e << CH_ELS_LO));
      pinLevel[0] <= 1'b1;
      tick(4);
      rd(ch(0, OFS_CH_SC));
      `CHK("rise capture", e != 2, rb[CH_CHF])
      wr(ch(0, OFS_CH_SC), 8'(e << CH_ELS_LO));
      pinLevel[0] <= 1'b0;
      tick(4);
      rd(ch(0, OFS_CH_SC));
      `CHK("fall capture", e != 1, rb[CH_CHF])
    end
    rd16(ch(0, OFS_CH_VH), cntY);
    `CHK("captured value", cntX, cntY)
    wr(OFS_SC, 8'h08);
    bgdActive <= 1'b1;
    rd16(OFS_CNTH, cntX);
    tick(10);
    rd16(OFS_CNTH, cntY);
    `CHK("debug freeze", cntX, cntY)
    bgdActive <= 1'b0;
    tick(5);
    wr(OFS_SC, 8'h00);
    wr(OFS_CNTL, 8'h5a);
    rd16(OFS_CNTH, cntX);
    `CHK("counter clear", CNT_RST, cntX)
    // stopped clock loads the modulo on the second byte
    wr16(OFS_MODH, 16'h0040);
    rd16(OFS_MODH, cntX);
    `CHK("modulo load", 16'h0040, cntX)
    wr(OFS_SC, 8'h08);
    tick(100);
    rd(OFS_SC);
    `CHK("overflow", 1'b1, rb[SC_TOF])
    rd16(OFS_CNTH, cntX);
    `CHK("count bound", 1'b1, cntX <= 16'h0040)
    // clearing the count first keeps a wrap out of the setup writes
    wr(OFS_CNTL, 8'h00);
    wr(OFS_SC, 8'h08);
    wr(OFS_MODH, 8'h00);
    tick(100);
    rd(OFS_SC);
    `CHK("overflow held", 1'b0, rb[SC_TOF])
    wr(OFS_MODL, 8'h40);
    tick(100);
    rd(OFS_SC);
    `CHK("overflow freed", 1'b1, rb[SC_TOF])
    wr(OFS_CNTL, 8'h00);
    wr(OFS_SC, 8'h08);
    wr(OFS_MODH, 8'h00);
    wr(OFS_SC, 8'h08);
    tick(100);
    rd(OFS_SC);
    `CHK("pair discarded", 1'b1, rb[SC_TOF])
    // modulo 5 gives a six-cycle period
    wr(OFS_SC, 8'h00);
    wr16(OFS_MODH, 16'h0005);
    // a count left above the new modulo would run to ffff first
    wr(OFS_CNTL, 8'h00);
    wr16(ch(1, OFS_CH_VH), 16'h0002);
    wr(ch(1, OFS_CH_SC), 8'h1c);
    wr(OFS_SC, 8'h08);
    tick(20);
    `CHK("compare set", 2'b11, {chOut[1], chOutEn[1]})
    wr(ch(1, OFS_CH_SC), 8'h18);
    tick(20);
    `CHK("compare clear", 1'b0, chOut[1])
    wr(ch(1, OFS_CH_SC), 8'h14);
    tick(20);
    a = chOut[1];
    tick(6);
    `CHK("compare toggle", ~a, chOut[1])
    wr(ch(1, OFS_CH_SC), 8'h10);
    tick(10);
    rd(ch(1, OFS_CH_SC));
    `CHK("software compare", 2'b10, {rb[CH_CHF], chOutEn[1]})
    for (int i = 0; i < 4; i++) begin
      wr(ch(1, OFS_CH_SC), (i == 3) ? 8'h24 : 8'h28);
      wr16(ch(1, OFS_CH_VH), EP_V[i]);
      tick(12);
      highs(12, hc);
      `CHK("edge pwm", EP_H[i], hc)
    end
    // modulo 4 with up/down counting gives an eight-cycle period
    wr(OFS_SC, 8'h00);
    wr16(OFS_MODH, 16'h0004);
    wr(OFS_CNTL, 8'h00);
    wr(OFS_SC, 8'h28);
    for (int i = 0; i < 5; i++) begin
      wr(ch(1, OFS_CH_SC), (i == 4) ? 8'h24 : 8'h28);
      wr16(ch(1, OFS_CH_VH), CP_V[i]);
      tick(8);
      highs(16, hc);
      `CHK("center pwm", CP_H[i], hc)
    end
    wrap_up();
  end
endmodule // tpu_top_bench
`default_nettype wire
